/* File: rtl/execution_command_handler.sv */
`timescale 1ns/1ps
`default_nettype none

module execution_command_handler
	import exec_cmd_pkg::*;
#(
	parameter int unsigned TMO_UNIT_CYCLES = TMO_UNIT_CYC,
	parameter int unsigned SOFT_RST_CYCLES = SOFT_RST_CYC,
	parameter bit          BOOT_CMD_EN     = 1'b1
) (
	// Clock and reset.
	input  wire logic               clk_i,
	input  wire logic               resetn_i,
	// APB slave.
	input  wire logic [ADDR_W-1:0]  paddr_i,
	input  wire logic               psel_i,
	input  wire logic               penable_i,
	input  wire logic               pwrite_i,
	input  wire logic [31:0]        pwdata_i,
	output logic [31:0]             prdata_o,
	output logic                    pready_o,
	output logic                    pslverr_o,
	// Boot strap pins.
	input  wire logic               din_i,
	input  wire logic               terminal_ready_n_i,
	input  wire logic               request_to_send_n_i,
	// Non-volatile store.
	output logic                    nvm_wr_o,
	output logic [NVM_W-1:0]        nvm_wdata_o,
	input  wire logic               nvm_done_i,
	input  wire logic [NVM_W-1:0]   nvm_rdata_i,
	// Effective settings and actions.
	output logic [RATE_W-1:0]       serial_rate_setting_o,
	output logic [TMO_W-1:0]        cmd_mode_inactivity_timeout_o,
	output logic [NET_W-1:0]        network_name_o,
	output logic                    cmd_mode_o,
	output logic                    ok_resp_o,
	output logic                    net_leave_o,
	output logic                    soft_reset_o,
	output logic                    run_bootloader_o,
	output logic                    fw_update_uart_o
);

	// ==========================================================
	// Reset release and pin synchronisers.
	logic       rst_meta_q;
	logic       rst_n;
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;
	logic [1:0] strap_cnt_q;
	logic       strap_done_q;

	// Assert at once, release after two edges.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rst_meta_q <= 1'b0;
			rst_n      <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n      <= rst_meta_q;
		end
	end

	// Two flops on each strap pin.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= {request_to_send_n_i, terminal_ready_n_i, din_i};
			pin_sync_q <= pin_meta_q;
		end
	end

	// ==========================================================
	// APB decode.
	logic       setup;
	logic       wr_fire;
	logic [3:0] cmd_code;
	logic [7:0] cmd_arg;
	logic       cmd_ok;
	logic       addr_ok;
	logic       persist_busy;
	persist_if  pif ();

	assign setup    = psel_i & ~penable_i;
	assign wr_fire  = psel_i & penable_i & pready_o & pwrite_i & ~pslverr_o;
	assign cmd_code = pwdata_i[CMD_CODE_LSB +: 4];
	assign cmd_arg  = pwdata_i[CMD_ARG_LSB +: 8];
	assign persist_busy = pif.busy;

	// Legal command check; anything refused answers with an error.
	always_comb begin
		cmd_ok = 1'b0;
		unique case (cmd_code)
			CMD_ENTER, CMD_EXIT, CMD_APPLY, CMD_API_FRAME,
			CMD_PERSIST, CMD_RESTORE, CMD_SOFT_RST: cmd_ok = 1'b1;
			CMD_NET_RST, CMD_NET_RST_AL: cmd_ok = (cmd_arg == ARG_NET_RST);
			CMD_BOOT: cmd_ok = BOOT_CMD_EN;
			CMD_FW_UPDATE: cmd_ok = (cmd_arg == ARG_PORT_UART);
			default: cmd_ok = 1'b0;
		endcase
	end

	// Map check per offset and direction.
	always_comb begin
		unique case (paddr_i)
			OFF_CMD:                              addr_ok = pwrite_i & cmd_ok & ~persist_busy;
			OFF_STATUS, OFF_RATE_PND, OFF_TMO_PND,
			OFF_NET_PND:                          addr_ok = 1'b1;
			OFF_RATE_ACT, OFF_TMO_ACT, OFF_NET_ACT: addr_ok = ~pwrite_i;
			default:                              addr_ok = 1'b0;
		endcase
	end

	logic is_cmd;
	logic do_apply;
	logic do_exit;
	logic tmo_expire;
	assign is_cmd = wr_fire & (paddr_i == OFF_CMD);

	assign do_exit = is_cmd & (cmd_code == CMD_EXIT);
	assign do_apply = (is_cmd & (cmd_code == CMD_APPLY)) | do_exit
		| (is_cmd & (cmd_code == CMD_API_FRAME) & (cmd_arg == ARG_APPLY_FRAME))
		| tmo_expire;

	// ==========================================================
	// Parameters: queued and effective copies.
	logic [RATE_W-1:0] rate_pnd_q;
	logic [TMO_W-1:0]  tmo_pnd_q;
	logic [NET_W-1:0]  net_pnd_q;
	logic              nvm_valid_q;
	logic              do_restore;
	logic              do_netrst;
	assign do_restore = is_cmd & (cmd_code == CMD_RESTORE);
	assign do_netrst  = is_cmd & ((cmd_code == CMD_NET_RST) | (cmd_code == CMD_NET_RST_AL));

	// Queued values take writes and reload from the store at start.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rate_pnd_q <= DEF_RATE;
			tmo_pnd_q  <= DEF_TMO;
			net_pnd_q  <= DEF_NET;
		end else if (!strap_done_q && strap_cnt_q == 2'h3 && nvm_rdata_i[NVM_W-1]) begin
			{rate_pnd_q, tmo_pnd_q, net_pnd_q} <= nvm_rdata_i[NVM_W-2:0];
		end else if (do_restore) begin
			rate_pnd_q <= DEF_RATE;
			tmo_pnd_q  <= DEF_TMO;
			net_pnd_q  <= DEF_NET;
		end else if (do_netrst) begin
			net_pnd_q <= DEF_NET;
		end else if (wr_fire) begin
			if (paddr_i == OFF_RATE_PND) rate_pnd_q <= pwdata_i[RATE_W-1:0];
			if (paddr_i == OFF_TMO_PND)  tmo_pnd_q  <= pwdata_i[TMO_W-1:0];
			if (paddr_i == OFF_NET_PND)  net_pnd_q  <= pwdata_i[NET_W-1:0];
		end
	end

	// Effective values change only on the store load at start, apply, restore or network reset.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			serial_rate_setting_o         <= DEF_RATE;
			cmd_mode_inactivity_timeout_o <= DEF_TMO;
			network_name_o                <= DEF_NET;
			nvm_valid_q                   <= 1'b0;
		end else if (!strap_done_q && strap_cnt_q == 2'h3 && nvm_rdata_i[NVM_W-1]) begin
			{serial_rate_setting_o, cmd_mode_inactivity_timeout_o, network_name_o}
				<= nvm_rdata_i[NVM_W-2:0];
			nvm_valid_q <= 1'b1;
		end else if (do_restore) begin
			serial_rate_setting_o         <= DEF_RATE;
			cmd_mode_inactivity_timeout_o <= DEF_TMO;
			network_name_o                <= DEF_NET;
		end else if (do_netrst) begin
			network_name_o <= DEF_NET;
		end else if (do_apply) begin
			serial_rate_setting_o         <= rate_pnd_q;
			cmd_mode_inactivity_timeout_o <= tmo_pnd_q;
			network_name_o                <= net_pnd_q;
		end
	end

	// ==========================================================
	// Command mode and inactivity timeout.
	logic [31:0]      unit_cnt_q;
	logic [TMO_W-1:0] unit_left_q;
	assign tmo_expire = cmd_mode_o & ~is_cmd & (unit_cnt_q == 32'h0)
		& (unit_left_q <= {{(TMO_W-1){1'b0}}, 1'b1});

	// Any valid command other than exit restarts the inactivity window.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cmd_mode_o  <= 1'b0;
			unit_cnt_q  <= '0;
			unit_left_q <= '0;
		end else if (is_cmd && cmd_code != CMD_EXIT) begin
			cmd_mode_o  <= 1'b1;
			unit_cnt_q  <= 32'(TMO_UNIT_CYCLES - 1);
			unit_left_q <= cmd_mode_inactivity_timeout_o;
		end else if (do_exit || tmo_expire) begin
			cmd_mode_o <= 1'b0;
		end else if (cmd_mode_o) begin
			if (unit_cnt_q == 32'h0) begin
				unit_cnt_q  <= 32'(TMO_UNIT_CYCLES - 1);
				unit_left_q <= unit_left_q - 1'b1;
			end else begin
				unit_cnt_q <= unit_cnt_q - 1'b1;
			end
		end
	end

	// ==========================================================
	// Persist, responses, reset delay and network leave.
	logic        ok_seen_q;
	logic        rst_pend_q;
	logic [31:0] rst_cnt_q;
	logic        ok_clr;

	assign pif.start = is_cmd & (cmd_code == CMD_PERSIST);
	assign pif.data  = {1'b1, serial_rate_setting_o, cmd_mode_inactivity_timeout_o,
		network_name_o};
	assign ok_clr = wr_fire & (paddr_i == OFF_STATUS) & pwdata_i[ST_OK];

	persist_engine u_persist (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n),
		.p           (pif.engine),
		.nvm_wr_o    (nvm_wr_o),
		.nvm_wdata_o (nvm_wdata_o),
		.nvm_done_i  (nvm_done_i)
	);

	// OK pulses after the store completes and at once for soft reset.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ok_resp_o   <= 1'b0;
			ok_seen_q   <= 1'b0;
			net_leave_o <= 1'b0;
		end else begin
			ok_resp_o   <= pif.done | (is_cmd & (cmd_code == CMD_SOFT_RST));
			net_leave_o <= do_netrst;
			if (ok_resp_o) begin
				ok_seen_q <= 1'b1;
			end else if (ok_clr) begin
				ok_seen_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			rst_pend_q   <= 1'b0;
			rst_cnt_q    <= '0;
			soft_reset_o <= 1'b0;
		end else begin
			soft_reset_o <= rst_pend_q & (rst_cnt_q == 32'h0);
			if (is_cmd && cmd_code == CMD_SOFT_RST && !rst_pend_q) begin
				rst_pend_q <= 1'b1;
				rst_cnt_q  <= 32'(SOFT_RST_CYCLES - 1);
			end else if (rst_pend_q) begin
				if (rst_cnt_q == 32'h0) begin
					rst_pend_q <= 1'b0;
				end else begin
					rst_cnt_q <= rst_cnt_q - 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Bootloader entry by strap or command.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			strap_cnt_q      <= '0;
			strap_done_q     <= 1'b0;
			run_bootloader_o <= 1'b0;
			fw_update_uart_o <= 1'b0;
		end else begin
			if (!strap_done_q) begin
				strap_cnt_q <= strap_cnt_q + 1'b1;
				if (strap_cnt_q == 2'h3) begin
					strap_done_q <= 1'b1;
					run_bootloader_o <= ~pin_sync_q[0] & ~pin_sync_q[1] & pin_sync_q[2];
				end
			end
			if (is_cmd && (cmd_code == CMD_BOOT || cmd_code == CMD_FW_UPDATE)) begin
				run_bootloader_o <= 1'b1;
			end
			if (is_cmd && cmd_code == CMD_FW_UPDATE) begin
				fw_update_uart_o <= 1'b1;
			end
		end
	end

	// ==========================================================
	// APB answer, registered in the setup cycle.
	logic [31:0] rdata_d;
	always_comb begin
		rdata_d = '0;
		unique case (paddr_i)
			OFF_STATUS: begin
				rdata_d[ST_CMD_MODE]  = cmd_mode_o;
				rdata_d[ST_BUSY]      = persist_busy;
				rdata_d[ST_OK]        = ok_seen_q;
				rdata_d[ST_BOOT]      = run_bootloader_o;
				rdata_d[ST_FW_UART]   = fw_update_uart_o;
				rdata_d[ST_RST_PEND]  = rst_pend_q;
				rdata_d[ST_NVM_VALID] = nvm_valid_q;
			end
			OFF_RATE_PND: rdata_d[RATE_W-1:0] = rate_pnd_q;
			OFF_RATE_ACT: rdata_d[RATE_W-1:0] = serial_rate_setting_o;
			OFF_TMO_PND:  rdata_d[TMO_W-1:0]  = tmo_pnd_q;
			OFF_TMO_ACT:  rdata_d[TMO_W-1:0]  = cmd_mode_inactivity_timeout_o;
			OFF_NET_PND:  rdata_d[NET_W-1:0]  = net_pnd_q;
			OFF_NET_ACT:  rdata_d[NET_W-1:0]  = network_name_o;
			default:      rdata_d = '0;
		endcase
	end

	// One setup cycle, then the access phase completes at once.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o  <= '0;
		end else begin
			pready_o  <= setup;
			pslverr_o <= setup & ~addr_ok;
			prdata_o  <= (setup & ~pwrite_i & addr_ok) ? rdata_d : 32'h0;
		end
	end

endmodule

`default_nettype wire

/* File: rtl/exec_cmd_pkg.sv */
package exec_cmd_pkg;

	// ==========================================================
	// Clock and timing.
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned TMO_UNIT_MS     = 100;
	localparam int unsigned SOFT_RST_DLY_MS = 2000;
	localparam int unsigned TMO_UNIT_CYC    = CLK_HZ / 1000 * TMO_UNIT_MS;
	localparam int unsigned SOFT_RST_CYC    = CLK_HZ / 1000 * SOFT_RST_DLY_MS;

	// ==========================================================
	// Bus and parameter widths.
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned RATE_W = 4;
	localparam int unsigned TMO_W  = 13;
	localparam int unsigned NET_W  = 16;
	localparam int unsigned NVM_W  = 1 + RATE_W + TMO_W + NET_W;

	// ==========================================================
	// Register byte offsets.
	localparam logic [ADDR_W-1:0] OFF_CMD      = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_RATE_PND = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_RATE_ACT = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_TMO_PND  = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_TMO_ACT  = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_NET_PND  = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_NET_ACT  = 8'h1c;

	// ==========================================================
	// Command register fields and codes.
	localparam int unsigned CMD_CODE_LSB = 0;
	localparam int unsigned CMD_ARG_LSB  = 8;
	localparam logic [3:0] CMD_ENTER      = 4'h1;
	localparam logic [3:0] CMD_EXIT       = 4'h2;
	localparam logic [3:0] CMD_APPLY      = 4'h3;
	localparam logic [3:0] CMD_API_FRAME  = 4'h4;
	localparam logic [3:0] CMD_PERSIST    = 4'h5;
	localparam logic [3:0] CMD_RESTORE    = 4'h6;
	localparam logic [3:0] CMD_SOFT_RST   = 4'h7;
	localparam logic [3:0] CMD_NET_RST    = 4'h8;
	localparam logic [3:0] CMD_NET_RST_AL = 4'h9;
	localparam logic [3:0] CMD_BOOT       = 4'ha;
	localparam logic [3:0] CMD_FW_UPDATE  = 4'hb;
	localparam logic [7:0] ARG_APPLY_FRAME = 8'h08;
	localparam logic [7:0] ARG_NET_RST     = 8'h00;
	localparam logic [7:0] ARG_PORT_UART   = 8'h00;

	// ==========================================================
	// Status register bit positions.
	localparam int unsigned ST_CMD_MODE  = 0;
	localparam int unsigned ST_BUSY      = 1;
	localparam int unsigned ST_OK        = 2;
	localparam int unsigned ST_BOOT      = 3;
	localparam int unsigned ST_FW_UART   = 4;
	localparam int unsigned ST_RST_PEND  = 5;
	localparam int unsigned ST_NVM_VALID = 6;

	// ==========================================================
	// Factory defaults.
	localparam logic [RATE_W-1:0] DEF_RATE = 4'h3;
	localparam logic [TMO_W-1:0]  DEF_TMO  = 13'h0064;
	localparam logic [NET_W-1:0]  DEF_NET  = 16'h0000;

endpackage

/* File: rtl/persist_if.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Handshake between the command handler and the store engine.
interface persist_if import exec_cmd_pkg::*; ();
	logic             start;
	logic [NVM_W-1:0] data;
	logic             busy;
	logic             done;

	modport ctrl   (output start, output data, input busy, input done);
	modport engine (input start, input data, output busy, output done);
endinterface

`default_nettype wire

/* File: rtl/persist_engine.sv */
`timescale 1ns/1ps
`default_nettype none

module persist_engine
	import exec_cmd_pkg::*;
(
	// Clock and synchronised reset.
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Handshake with the command handler.
	persist_if.engine             p,
	// Non-volatile store port.
	output logic                  nvm_wr_o,
	output logic [NVM_W-1:0]      nvm_wdata_o,
	input  wire logic             nvm_done_i
);

	typedef enum logic [1:0] {S_IDLE, S_WRITE, S_DONE} eng_state_t;

	eng_state_t state_q;

	// ==========================================================
	// Sequencer: latch the image, hold the write until acknowledged.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q     <= S_IDLE;
			nvm_wr_o    <= 1'b0;
			nvm_wdata_o <= '0;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					if (p.start) begin
						state_q     <= S_WRITE;
						nvm_wr_o    <= 1'b1;
						nvm_wdata_o <= p.data;
					end
				end
				S_WRITE: begin
					if (nvm_done_i) begin
						state_q  <= S_DONE;
						nvm_wr_o <= 1'b0;
					end
				end
				S_DONE: begin
					state_q <= S_IDLE;
				end
			endcase
		end
	end

	// Busy covers the whole write, done pulses once after it.
	assign p.busy = (state_q != S_IDLE);
	assign p.done = (state_q == S_DONE);

endmodule

`default_nettype wire

/* File: test/exec_cmd_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port checker for the command handler.
module exec_cmd_monitor
	import exec_cmd_pkg::*;
#(
	parameter int unsigned SOFT_RST_CYCLES = 20
) (
	// Clock, reset and bus.
	input wire logic              clk_i,
	input wire logic              resetn_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic              psel_i,
	input wire logic              penable_i,
	input wire logic              pwrite_i,
	input wire logic [31:0]       pwdata_i,
	input wire logic              pready_o,
	input wire logic              pslverr_o,
	// Store port.
	input wire logic              nvm_wr_o,
	input wire logic [NVM_W-1:0]  nvm_wdata_o,
	input wire logic              nvm_done_i,
	// Settings and actions.
	input wire logic [RATE_W-1:0] serial_rate_setting_o,
	input wire logic [TMO_W-1:0]  cmd_mode_inactivity_timeout_o,
	input wire logic [NET_W-1:0]  network_name_o,
	input wire logic              cmd_mode_o,
	input wire logic              ok_resp_o,
	input wire logic              net_leave_o,
	input wire logic              soft_reset_o,
	input wire logic              run_bootloader_o
);
	localparam int RST_TAIL = SOFT_RST_CYCLES - 7;
	logic       cmd_acc;
	logic [3:0] code;
	logic       chg;
	logic       mode_q;
	logic [3:0] up_q;

	// Accepted command writes and those that move queued values or the default rate into effect.
	assign cmd_acc = psel_i & penable_i & pready_o & ~pslverr_o & pwrite_i & (paddr_i == OFF_CMD);
	assign code = pwdata_i[3:0];
	assign chg = cmd_acc & (code == CMD_APPLY | code == CMD_EXIT | code == CMD_RESTORE
		| (code == CMD_API_FRAME & pwdata_i[15:8] == ARG_APPLY_FRAME));

	// Cycles since reset, so the boot-time image load is not flagged.
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			up_q   <= 4'h0;
			mode_q <= 1'b0;
		end else begin
			up_q   <= up_q + {3'h0, ~&up_q};
			mode_q <= cmd_mode_o;
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	sequence cmd_s(logic [3:0] c);
		cmd_acc && code == c;
	endsequence
	sequence store_done_s;
		nvm_wr_o && nvm_done_i;
	endsequence

	chk_pready_next: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no answer after setup");
	chk_rate_held: assert property (up_q == 4'hf && $changed(serial_rate_setting_o)
		|-> $past(chg) || $fell(cmd_mode_o) || (!mode_q && $past(mode_q)))
		else $error("rate changed without apply");
	chk_ok_now: assert property (cmd_s(CMD_SOFT_RST) |=> ok_resp_o && !soft_reset_o)
		else $error("no prompt ok on soft reset");
	chk_rst_late: assert property (cmd_s(CMD_SOFT_RST)
		|=> !soft_reset_o [*8] ##RST_TAIL soft_reset_o)
		else $error("soft reset at wrong time");
	chk_restore_defs: assert property (cmd_s(CMD_RESTORE) |=> serial_rate_setting_o == DEF_RATE
		&& cmd_mode_inactivity_timeout_o == DEF_TMO && network_name_o == DEF_NET)
		else $error("defaults not restored");
	chk_net_clear: assert property (cmd_acc && (code == CMD_NET_RST || code == CMD_NET_RST_AL)
		|=> net_leave_o && network_name_o == 16'h0000)
		else $error("network not reset");
	chk_store_img: assert property (cmd_s(CMD_PERSIST) |=> nvm_wr_o && nvm_wdata_o ==
		{1'b1, serial_rate_setting_o, cmd_mode_inactivity_timeout_o, network_name_o})
		else $error("store image wrong");
	chk_store_hold: assert property (nvm_wr_o && !nvm_done_i |=> nvm_wr_o && $stable(nvm_wdata_o))
		else $error("store request dropped");
	chk_store_ok: assert property (store_done_s |=> !nvm_wr_o ##1 ok_resp_o)
		else $error("no ok after store");
	chk_spi_refused: assert property (psel_i && penable_i && pready_o && pwrite_i
		&& paddr_i == OFF_CMD && code == CMD_FW_UPDATE && pwdata_i[15:8] != ARG_PORT_UART |-> pslverr_o)
		else $error("non-uart update accepted");
	chk_boot_cmd: assert property (cmd_s(CMD_BOOT) |=> run_bootloader_o)
		else $error("boot command ignored");
endmodule

bind execution_command_handler exec_cmd_monitor #(.SOFT_RST_CYCLES(SOFT_RST_CYCLES)) u_exec_cmd_monitor (
	.clk_i(clk_i), .resetn_i(resetn_i), .paddr_i(paddr_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.pslverr_o(pslverr_o), .nvm_wr_o(nvm_wr_o), .nvm_wdata_o(nvm_wdata_o), .nvm_done_i(nvm_done_i),
	.serial_rate_setting_o(serial_rate_setting_o),
	.cmd_mode_inactivity_timeout_o(cmd_mode_inactivity_timeout_o),
	.network_name_o(network_name_o), .cmd_mode_o(cmd_mode_o), .ok_resp_o(ok_resp_o),
	.net_leave_o(net_leave_o), .soft_reset_o(soft_reset_o), .run_bootloader_o(run_bootloader_o));

`default_nettype wire

/* File: test/nvm_store_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Store model: acknowledges a write after a wait and keeps the image.
module nvm_store_model
	import exec_cmd_pkg::*;
#(
	parameter int unsigned WAIT_CYC = 5
) (
	// Clock.
	input  wire logic             clk_i,
	// Write request and stored image, kept across resets.
	input  wire logic             wr_i,
	input  wire logic [NVM_W-1:0] wdata_i,
	output logic                  done_o,
	output logic [NVM_W-1:0]      rdata_o
);
	logic [7:0]       cnt_q = 8'h00;
	logic [NVM_W-1:0] mem_q = '0;
	logic             done_q = 1'b0;

	assign done_o = done_q;
	assign rdata_o = mem_q;

	always_ff @(posedge clk_i) begin
		if (done_q) begin
			done_q <= 1'b0;
			cnt_q  <= 8'h00;
		end else if (wr_i) begin
			if (cnt_q == 8'(WAIT_CYC)) begin
				done_q <= 1'b1;
				mem_q  <= wdata_i;
			end else begin
				cnt_q <= cnt_q + 8'h01;
			end
		end
	end
endmodule

`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench for the command handler.
module tb
	import exec_cmd_pkg::*;
;
	logic              clk = 1'b0;
	logic              resetn = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              din = 1'b1;
	logic              trn = 1'b1;
	logic              rtsn = 1'b1;
	logic              nvm_wr;
	logic              nvm_done;
	logic [NVM_W-1:0]  nvm_wdata;
	logic [NVM_W-1:0]  nvm_rdata;
	logic [RATE_W-1:0] rate;
	logic [TMO_W-1:0]  tmo;
	logic [NET_W-1:0]  name;
	logic              mode;
	logic              ok;
	logic              leave;
	logic              srst;
	logic              boot;
	logic              fwu;
	int                failures = 0;
	int                comparisons = 0;
	int                n;

	// Clock at 40 MHz.
	always #12.5 clk = ~clk;

	execution_command_handler #(.TMO_UNIT_CYCLES(10), .SOFT_RST_CYCLES(20))
	u_execution_command_handler (
		.clk_i(clk), .resetn_i(resetn), .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .din_i(din), .terminal_ready_n_i(trn), .request_to_send_n_i(rtsn),
		.nvm_wr_o(nvm_wr), .nvm_wdata_o(nvm_wdata), .nvm_done_i(nvm_done), .nvm_rdata_i(nvm_rdata),
		.serial_rate_setting_o(rate), .cmd_mode_inactivity_timeout_o(tmo), .network_name_o(name),
		.cmd_mode_o(mode), .ok_resp_o(ok), .net_leave_o(leave), .soft_reset_o(srst),
		.run_bootloader_o(boot), .fw_update_uart_o(fwu));

	nvm_store_model #(.WAIT_CYC(5)) u_nvm_store_model (.clk_i(clk), .wr_i(nvm_wr),
		.wdata_i(nvm_wdata), .done_o(nvm_done), .rdata_o(nvm_rdata));

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; for reads d is the expected data.
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= w ? d : 32'h0;
		@(posedge clk);
		penable <= 1'b1;
		// Hold the request until pready is sampled high at a rising edge; the watchdog ends a hang.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		check("slave error", {31'h0, pslverr}, {31'h0, err});
		if (!w && !err) check("read data", prdata, d);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cmd(input logic [3:0] c, input logic [7:0] arg, input logic err);
		xfer(1'b1, OFF_CMD, {16'h0, arg, 4'h0, c}, err);
		@(negedge clk);
	endtask

	task automatic do_reset(input logic strap);
		@(posedge clk);
		din <= ~strap;
		trn <= ~strap;
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (8) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic give_verdict;
		if (failures == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// Main sequence.
	initial begin
		do_reset(1'b0);
		check("boot", 32'(boot), 32'h0);
		xfer(1'b0, OFF_RATE_ACT, 32'(DEF_RATE), 1'b0);
		xfer(1'b0, OFF_CMD, 32'h0, 1'b1);
		xfer(1'b1, OFF_RATE_ACT, 32'h1, 1'b1);
		xfer(1'b1, 8'h40, 32'h1, 1'b1);
		xfer(1'b1, OFF_RATE_PND, 32'h5, 1'b0);
		check("rate", 32'(rate), 32'(DEF_RATE));
		cmd(CMD_APPLY, 8'h00, 1'b0);
		check("rate", 32'(rate), 32'h5);
		xfer(1'b1, OFF_RATE_PND, 32'h6, 1'b0);
		cmd(CMD_API_FRAME, 8'h01, 1'b0);
		check("rate", 32'(rate), 32'h5);
		cmd(CMD_API_FRAME, ARG_APPLY_FRAME, 1'b0);
		check("rate", 32'(rate), 32'h6);
		xfer(1'b1, OFF_RATE_PND, 32'h7, 1'b0);
		cmd(CMD_EXIT, 8'h00, 1'b0);
		check("rate", 32'(rate), 32'h7);
		check("mode", 32'(mode), 32'h0);
		xfer(1'b1, OFF_TMO_PND, 32'h2, 1'b0);
		xfer(1'b1, OFF_NET_PND, 32'h1234, 1'b0);
		cmd(CMD_ENTER, 8'h00, 1'b0);
		cmd(CMD_APPLY, 8'h00, 1'b0);
		// Reload the window so the newly applied two-unit timeout is the one that runs.
		cmd(CMD_ENTER, 8'h00, 1'b0);
		xfer(1'b1, OFF_RATE_PND, 32'h9, 1'b0);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (mode !== 1'b0 && n < 200);
		check("rate", 32'(rate), 32'h9);
		cmd(CMD_RESTORE, 8'h00, 1'b0);
		check("rate", 32'(rate), 32'(DEF_RATE));
		check("timeout", 32'(tmo), 32'(DEF_TMO));
		check("name", 32'(name), 32'(DEF_NET));
		xfer(1'b0, OFF_TMO_PND, 32'(DEF_TMO), 1'b0);
		for (int i = 0; i < 2; i++) begin
			xfer(1'b1, OFF_NET_PND, 32'hbeef, 1'b0);
			cmd(CMD_APPLY, 8'h00, 1'b0);
			cmd(i == 0 ? CMD_NET_RST : CMD_NET_RST_AL, ARG_NET_RST, 1'b0);
			check("leave", 32'(leave), 32'h1);
			check("name", 32'(name), 32'h0);
			xfer(1'b0, OFF_NET_PND, 32'h0, 1'b0);
		end
		cmd(CMD_NET_RST, 8'h01, 1'b1);
		cmd(CMD_FW_UPDATE, 8'h01, 1'b1);
		check("uart update", 32'(fwu), 32'h0);
		cmd(CMD_SOFT_RST, 8'h00, 1'b0);
		check("ok", 32'(ok), 32'h1);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (srst !== 1'b1 && n < 100);
		check("reset delay", 32'(n), 32'd20);
		xfer(1'b1, OFF_RATE_PND, 32'ha, 1'b0);
		cmd(CMD_APPLY, 8'h00, 1'b0);
		cmd(CMD_PERSIST, 8'h00, 1'b0);
		cmd(CMD_APPLY, 8'h00, 1'b1);
		n = 0;
		while (ok !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		check("ok", 32'(ok), 32'h1);
		xfer(1'b0, OFF_STATUS, 32'h5, 1'b0);
		xfer(1'b1, OFF_STATUS, 32'h4, 1'b0);
		xfer(1'b0, OFF_STATUS, 32'h1, 1'b0);
		cmd(CMD_FW_UPDATE, ARG_PORT_UART, 1'b0);
		check("uart update", 32'(fwu), 32'h1);
		cmd(CMD_BOOT, 8'h00, 1'b0);
		check("boot", 32'(boot), 32'h1);
		do_reset(1'b1);
		check("rate", 32'(rate), 32'ha);
		check("boot", 32'(boot), 32'h1);
		xfer(1'b0, OFF_STATUS, 32'h48, 1'b0);
		give_verdict();
	end

	// Watchdog against a hung handshake.
	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		give_verdict();
	end
endmodule

`default_nettype wire
